// ### hw/llbs_core.sv
// light-load sequencing: foldback, skip/burst, blanking, peak stop, soft-start,
// winding-short trip, overpower gating and line-peak validation
// assumes comparator flags from analog pins, a 40 MHz clock and a supply reset
`timescale 1ns/100ps
// Function
// - foldback lengthens period linearly to minimum
// - maximum on-time limit always enforced
// - jitter keeps running during foldback
// - freeze setpoint at 300 mV below freeze
// - skip stops pulses until skip exit
// - skip entry waits for pulse end
// - burst repetition limited by holdoff timer
// - skip exit resumes, starts timer and counter
// - stop only after minimum burst pulses
// - no restart before holdoff expires
// - expiry alone never starts a burst
// - transient level leaves burst at once
// - blank 250 ns, then feedback threshold stops
// - 0.7 V ceiling comparator also stops
// - soft-start ramps setpoint in 32 steps
// - frequency rises with soft-start ramp
// - winding short enters protection at once
// - overpower source only above enable level
// - line peak sampled and reset on events
// - peak valid after 2 quiet sample clocks
// - duty never exceeds 80 percent
// - triangle jitter at 125 Hz
module llbs_core #(
	parameter int unsigned SS_CYCLES = llbs_pkg::SS_CYC_DEF,
	parameter int unsigned HOLD_CYCLES = llbs_pkg::HOLD_CYC_DEF,
	parameter int unsigned BURST_MIN = llbs_pkg::BURST_MIN_DEF
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic fb_below_fold_start,
	input wire logic fb_below_fold_end,
	input wire logic [4:0] fold_code,
	input wire logic fb_below_freeze,
	input wire logic fb_skip_in,
	input wire logic fb_above_skip_out,
	input wire logic fb_above_transient,
	input wire logic fb_above_overpower,
	input wire logic cs_at_feedback,
	input wire logic cs_at_max,
	input wire logic cs_at_soft_start,
	input wire logic cs_at_short,
	input wire logic line_cmp,
	input wire logic line_sample,
	input wire logic [4:0] line_code,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic gate_drive_out,
	output logic protect_mode,
	output logic low_power,
	output logic setpoint_freeze,
	output logic overpower_enable,
	output logic [4:0] ss_setpoint_code,
	output logic [4:0] line_peak,
	output logic line_peak_valid,
	output logic line_peak_reset
);
	import llbs_pkg::*;

	// ************************************
	// state record
	// ************************************
	typedef struct packed {
		llbs_state_t fsm; // light-load mode
		logic [NFLAG-1:0] s1; // first sync stage, read only by s2
		logic [NFLAG-1:0] s2; // usable flags
		logic [4:0] fc1; // fold code sync
		logic [4:0] fc2;
		logic [4:0] ad1; // line code sync
		logic [4:0] ad2;
		logic lc_d; // comparator history
		logic smp_d; // sample clock history
		logic [10:0] osc_cnt; // position in period
		logic [10:0] period; // current period length
		logic [10:0] on_cnt; // cycles since pulse start
		logic gate; // drive pulse
		logic [7:0] jit; // signed jitter offset
		logic jdir; // triangle direction, 1 = up
		logic [11:0] jdiv; // jitter step divider
		logic [4:0] ss_step; // ramp step
		logic ss_done; // ramp at limit
		logic [12:0] ss_div; // step divider
		logic [15:0] hold_cnt; // holdoff count
		logic hold_run; // holdoff not yet expired
		logic [3:0] bcnt; // pulses in this burst
		logic skip_seen; // skip entry seen in burst
		logic protect;
		logic low_power;
		logic freeze;
		logic opc;
		logic [1:0] lv_cnt; // quiet sample clocks
		logic lv_arm; // counting after a falling edge
		logic [4:0] line_peak;
		logic line_valid;
		logic line_rst;
		logic [7:0] ctrl; // control register
		logic [7:0] rdata;
	} llbs_st_t;

	localparam llbs_st_t ST_INIT = '{
		fsm: ST_RUN,
		jdir: 1'b1,
		period: 11'(MIN_P), // first period at the lowest rate, the same rate the soft-start ramp begins at
		ctrl: CTRL_RESET,
		default: '0
	};
	localparam logic [12:0] SS_STEP_CYC = 13'(SS_CYCLES / SS_STEPS);
	localparam logic [15:0] HOLD_LOAD = 16'(HOLD_CYCLES - 1);
	localparam logic [3:0] BMIN = 4'(BURST_MIN);

	llbs_st_t st; // registered state
	llbs_st_t n; // next state
	logic rst_meta; // reset release stage one
	logic rst_sync_n; // reset used by the design

	// ************************************
	// reset release
	// ************************************
	// async assert, two-stage release avoids recovery races
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ************************************
	// next-state logic
	// ************************************
	always_comb begin
		logic [NFLAG-1:0] f; // synchronised flags
		logic [5:0] fk; // foldback depth 0..32
		logic [5:0] sk; // soft-start depth 0..32
		int fp; // foldback period
		int sp; // soft-start period
		int np; // chosen period
		logic wrap; // end of period
		logic may_start; // a new pulse is allowed
		logic burst_stop; // burst may end
		logic blank; // sense ignored
		logic pk_end; // peak current reached
		logic t_end; // time limit reached
		logic start; // pulse starts now
		logic lc_rise;
		logic lc_fall;
		logic smp_rise;
		f = st.s2;
		fk = '0;
		sk = '0;
		fp = 0;
		sp = 0;
		np = 0;
		wrap = 1'b0;
		may_start = 1'b0;
		burst_stop = 1'b0;
		blank = 1'b0;
		pk_end = 1'b0;
		t_end = 1'b0;
		start = 1'b0;
		lc_rise = 1'b0;
		lc_fall = 1'b0;
		smp_rise = 1'b0;
		n = st;

		// two flops on every pin flag before use
		n.s1 = {line_sample, line_cmp, cs_at_short, cs_at_soft_start, cs_at_max,
			cs_at_feedback, fb_above_overpower, fb_above_transient,
			fb_above_skip_out, fb_skip_in, fb_below_freeze, fb_below_fold_end,
			fb_below_fold_start};
		n.s2 = st.s1;
		// code busses may tear on a change; a one-period glitch only
		n.fc1 = fold_code;
		n.fc2 = st.fc1;
		n.ad1 = line_code;
		n.ad2 = st.ad1;

		// triangle jitter, free-running in every mode
		if (st.jdiv == 12'(JIT_STEP - 1)) begin
			n.jdiv = '0;
			if (st.jdir) begin
				n.jit = st.jit + 8'h01;
				if ($signed(st.jit) == $signed(8'(JIT_P - 1))) begin
					n.jdir = 1'b0;
				end
			end else begin
				n.jit = st.jit - 8'h01;
				if ($signed(st.jit) == -$signed(8'(JIT_P - 1))) begin
					n.jdir = 1'b1;
				end
			end
		end else begin
			n.jdiv = st.jdiv + 12'h001;
		end

		// soft-start ramp after every start
		if (!st.ss_done) begin
			if (st.ss_div == SS_STEP_CYC - 13'h0001) begin
				n.ss_div = '0;
				if (st.ss_step == 5'h1F) begin
					n.ss_done = 1'b1;
				end else begin
					n.ss_step = st.ss_step + 5'h01;
				end
			end else begin
				n.ss_div = st.ss_div + 13'h0001;
			end
		end

		// period: the slower of foldback and soft-start, plus jitter
		if (f[F_FOLD_E]) begin
			fk = 6'h20;
		end else if (f[F_FOLD_S]) begin
			fk = {1'b0, st.fc2};
		end
		if (!st.ss_done) begin
			sk = 6'h20 - {1'b0, st.ss_step};
		end
		fp = int'(NOM_P) + ((int'(SPAN_P) * int'(fk)) >>> 5);
		sp = int'(NOM_P) + ((int'(SPAN_P) * int'(sk)) >>> 5);
		np = ((fp > sp) ? fp : sp) + int'($signed(st.jit));

		// holdoff runs on its own once loaded
		if (st.hold_run) begin
			if (st.hold_cnt == '0) begin
				n.hold_run = 1'b0;
			end else begin
				n.hold_cnt = st.hold_cnt - 16'h0001;
			end
		end

		// which mode may start a pulse
		burst_stop = st.skip_seen && (st.bcnt >= BMIN);
		case (st.fsm)
			ST_RUN: may_start = !f[F_SKIP_IN];
			ST_BURST: may_start = !burst_stop;
			default: may_start = 1'b0;
		endcase
		may_start = may_start && st.ctrl[CTRL_DRV_EN];

		// oscillator and pulse timing
		wrap = (st.osc_cnt >= st.period - 11'h001);
		if (wrap) begin
			n.osc_cnt = '0;
			n.period = 11'(np);
			start = may_start && !st.gate;
		end else begin
			n.osc_cnt = st.osc_cnt + 11'h001;
		end
		blank = (st.on_cnt < 11'(LEB_CYC));
		pk_end = !blank && (f[F_CS_FB] || f[F_CS_MAX] ||
			(f[F_CS_SS] && !st.ss_done));
		t_end = (st.on_cnt >= 11'(MAX_ON_CYC - 1)) ||
			(st.on_cnt >= 11'((int'(st.period) * int'(DUTY_NUM)) >>> 6));
		if (st.gate) begin
			n.on_cnt = st.on_cnt + 11'h001;
			if (pk_end || t_end) begin
				n.gate = 1'b0;
				if (st.fsm == ST_BURST && st.bcnt != 4'hF) begin
					n.bcnt = st.bcnt + 4'h1;
				end
			end
		end else if (start) begin
			n.gate = 1'b1;
			n.on_cnt = '0;
		end

		// light-load mode sequencing
		case (st.fsm)
			ST_RUN: begin
				// stop only once the running pulse has ended
				if (f[F_SKIP_IN] && !st.gate) begin
					n.fsm = ST_STOP;
				end
			end
			ST_STOP: begin
				if (f[F_TRAN]) begin
					n.fsm = ST_RUN;
				end else if (f[F_SKIP_OUT] && !st.hold_run) begin
					// level seen after expiry, never expiry alone
					n.fsm = ST_BURST;
					n.hold_cnt = HOLD_LOAD;
					n.hold_run = 1'b1;
					n.bcnt = '0;
					n.skip_seen = 1'b0;
				end
			end
			ST_BURST: begin
				if (f[F_TRAN]) begin
					n.fsm = ST_RUN;
				end else begin
					if (f[F_SKIP_IN]) begin
						n.skip_seen = 1'b1;
					end
					if (burst_stop && !st.gate) begin
						n.fsm = ST_STOP;
					end
				end
			end
			default: n.fsm = ST_PROT; // latched until supply reset
		endcase
		// winding short overrides everything, even blanking
		if (f[F_CS_SHORT]) begin
			n.fsm = ST_PROT;
			n.gate = 1'b0;
		end
		if (st.fsm == ST_PROT) begin
			n.gate = 1'b0;
		end
		n.protect = (n.fsm == ST_PROT);
		n.low_power = (n.fsm == ST_STOP);

		// setpoint freeze and overpower gating
		n.freeze = f[F_FOLD_S] && f[F_FREEZE];
		n.opc = f[F_OPC];

		// line peak validation
		n.lc_d = f[F_LINE_CMP];
		n.smp_d = f[F_LINE_SMP];
		lc_rise = f[F_LINE_CMP] && !st.lc_d;
		lc_fall = !f[F_LINE_CMP] && st.lc_d;
		smp_rise = f[F_LINE_SMP] && !st.smp_d;
		n.line_rst = smp_rise;
		if (lc_rise || lc_fall) begin
			// any edge restarts the quiet count
			n.lv_cnt = '0;
			n.lv_arm = lc_fall;
		end else if (smp_rise && st.lv_arm) begin
			if (st.lv_cnt == 2'(LV_SAMPLES - 1)) begin
				n.line_peak = st.ad2;
				n.line_valid = 1'b1;
				n.lv_arm = 1'b0;
				n.lv_cnt = '0;
			end else begin
				n.lv_cnt = st.lv_cnt + 2'h1;
			end
		end

		// register port: write, then read data for one cycle
		if (reg_wr && reg_addr == REG_CTRL) begin
			n.ctrl = {7'h00, reg_wdata[CTRL_DRV_EN]};
		end
		n.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: n.rdata = st.ctrl;
				REG_STATUS: n.rdata = {st.line_valid, st.hold_run, st.ss_done,
					st.protect, st.gate, st.low_power, st.fsm};
				REG_LINE: n.rdata = {3'h0, st.line_peak};
				default: n.rdata = 8'h00; // unmapped reads as zero
			endcase
		end
	end

	// ************************************
	// state register
	// ************************************
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st <= ST_INIT;
		end else begin
			st <= n;
		end
	end

	// ************************************
	// outputs straight from flops
	// ************************************
	assign gate_drive_out = st.gate;
	assign protect_mode = st.protect;
	assign low_power = st.low_power;
	assign setpoint_freeze = st.freeze;
	assign overpower_enable = st.opc;
	assign ss_setpoint_code = st.ss_step;
	assign line_peak = st.line_peak;
	assign line_peak_valid = st.line_valid;
	assign line_peak_reset = st.line_rst;
	assign reg_rdata = st.rdata;
endmodule

// ### pkg/llbs_pkg.sv
// shared constants and types for the light-load burst and soft-start block
// assumes a single 40 MHz oscillator clock; comparator flags arrive asynchronously
package llbs_pkg;
	// ************************************
	// clock and oscillator
	// ************************************
	localparam int unsigned CLK_HZ = 40_000_000; // core clock
	localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int unsigned NOM_HZ = 65_000; // nominal switching rate
	localparam int unsigned MIN_HZ = 25_000; // minimum_switch_frequency, plain default
	localparam int unsigned JIT_HZ = 4_000; // jitter deviation
	localparam int unsigned JIT_RATE_HZ = 125; // triangle rate
	localparam int unsigned NOM_P = CLK_HZ / NOM_HZ; // nominal period, cycles
	localparam int unsigned MIN_P = CLK_HZ / MIN_HZ; // longest period, cycles
	localparam int unsigned SPAN_P = MIN_P - NOM_P;
	localparam int unsigned JIT_P = CLK_HZ / (NOM_HZ - JIT_HZ) - NOM_P;
	localparam int unsigned JIT_STEP = CLK_HZ / (JIT_RATE_HZ * 4 * JIT_P);
	localparam int unsigned DUTY_PCT = 80; // duty ceiling
	localparam int unsigned DUTY_NUM = (DUTY_PCT * 64) / 100; // in 1/64ths
	// ************************************
	// timing figures
	// ************************************
	localparam int unsigned MAX_ON_NS = 12_000; // on-time ceiling, plain default
	localparam int unsigned MAX_ON_CYC = (MAX_ON_NS * CLK_MHZ) / 1000;
	localparam int unsigned LEB_NS = 250; // blanking window
	localparam int unsigned LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SS_MS = 4; // soft_start_duration
	localparam int unsigned SS_CYC_DEF = SS_MS * (CLK_HZ / 1000);
	localparam int unsigned SS_STEPS = 32;
	localparam int unsigned HOLD_US = 1250; // burst holdoff
	localparam int unsigned HOLD_CYC_DEF = HOLD_US * CLK_MHZ;
	localparam int unsigned BURST_MIN_DEF = 3; // minimum pulses per burst
	localparam int unsigned LV_SAMPLES = 2; // quiet sample clocks for validity
	// ************************************
	// synchronised flag indices
	// ************************************
	localparam int F_FOLD_S = 0; // feedback below foldback start
	localparam int F_FOLD_E = 1; // feedback below foldback end
	localparam int F_FREEZE = 2; // feedback below freeze level
	localparam int F_SKIP_IN = 3; // feedback at skip entry
	localparam int F_SKIP_OUT = 4; // feedback above skip exit
	localparam int F_TRAN = 5; // feedback above transient level
	localparam int F_OPC = 6; // feedback above overpower_enable_level
	localparam int F_CS_FB = 7; // sense at feedback threshold
	localparam int F_CS_MAX = 8; // sense at 0.7 V ceiling
	localparam int F_CS_SS = 9; // sense at soft-start ramp
	localparam int F_CS_SHORT = 10; // sense at winding-short level
	localparam int F_LINE_CMP = 11; // line unplug detector comparator
	localparam int F_LINE_SMP = 12; // line sample clock
	localparam int NFLAG = 13;
	// ************************************
	// register port map
	// ************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_LINE = 4'h2;
	localparam int CTRL_DRV_EN = 0; // drive enable bit
	localparam logic [7:0] CTRL_RESET = 8'h01;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_STOP = 2'b01,
		ST_BURST = 2'b10,
		ST_PROT = 2'b11
	} llbs_state_t;
endpackage

// ### dv/llbs_core_asserts.sv
// port-level checker for the light-load burst and soft-start core
// assumes the core's ports by name and its parameters handed on by bind
`timescale 1ns/100ps
module llbs_core_asserts
	import llbs_pkg::*;
#(
	parameter int unsigned SS_CYCLES = SS_CYC_DEF,
	parameter int unsigned HOLD_CYCLES = HOLD_CYC_DEF,
	parameter int unsigned BURST_MIN = BURST_MIN_DEF
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic cs_at_short,
	input wire logic fb_above_overpower,
	input wire logic fb_below_freeze,
	input wire logic fb_below_fold_start,
	input wire logic fb_above_transient,
	input wire logic line_sample,
	input wire logic gate_drive_out,
	input wire logic protect_mode,
	input wire logic low_power,
	input wire logic setpoint_freeze,
	input wire logic overpower_enable,
	input wire logic [4:0] ss_setpoint_code,
	input wire logic line_peak_reset
);
	// ****
	// helper
	// ****
	logic [9:0] on_cnt; // high cycles of the pulse so far
	// counts drive-high cycles; a plain counter keeps the long bounds out of repetitions
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			on_cnt <= '0;
		end else begin
			on_cnt <= gate_drive_out ? on_cnt + 10'h001 : 10'h000;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// ****
	// assertions
	// ****
	short_trip_a: assert property (cs_at_short |-> ##[1:4] protect_mode)
		else $error("winding short did not trip protection");
	prot_gate_a: assert property (protect_mode && $past(protect_mode) |-> !gate_drive_out)
		else $error("drive active in protection");
	blank_window_a: assert property ($fell(gate_drive_out) |-> protect_mode || on_cnt >= LEB_CYC)
		else $error("pulse ended inside blanking");
	max_on_a: assert property (gate_drive_out |-> on_cnt <= MAX_ON_CYC)
		else $error("on-time ceiling exceeded");
	skip_quiet_a: assert property (low_power |-> !gate_drive_out)
		else $error("drive active while stopped");
	ss_step_a: assert property ($changed(ss_setpoint_code) |-> ss_setpoint_code == $past(ss_setpoint_code) + 5'h01)
		else $error("soft-start step not single");
	opc_on_a: assert property (fb_above_overpower [*7] |-> overpower_enable)
		else $error("overpower source not enabled");
	opc_off_a: assert property (!fb_above_overpower [*7] |-> !overpower_enable)
		else $error("overpower source on at light load");
	setpoint_hold_a: assert property ((fb_below_freeze && fb_below_fold_start) [*7] |-> setpoint_freeze)
		else $error("setpoint not frozen");
	tran_exit_a: assert property (fb_above_transient [*7] |-> !low_power)
		else $error("still stopped above transient level");
	line_event_a: assert property ($rose(line_sample) |-> ##[1:5] line_peak_reset ##1 !line_peak_reset)
		else $error("peak detector event missing or long");
endmodule
bind llbs_core llbs_core_asserts #(.SS_CYCLES(SS_CYCLES), .HOLD_CYCLES(HOLD_CYCLES), .BURST_MIN(BURST_MIN))
	llbs_core_asserts_inst (.*);

// ### dv/llbs_switch_model.sv
// model of the power switch and current-sense network behind the drive pin
// assumes drive high turns the switch on; sensed current climbs one step a clock
`timescale 1ns/100ps
module llbs_switch_model #(
	parameter int unsigned MAX_LVL = 150 // 0.7 V ceiling, in ramp steps
) (
	input wire logic clk,
	input wire logic gate_drive_out,
	input wire logic [4:0] ss_setpoint_code,
	input wire logic [9:0] fb_lvl, // feedback stop level, in ramp steps
	input wire logic short_en, // winding short commanded by a scenario
	input wire logic sense_open, // open sense path: only on-time ends the pulse
	output logic cs_at_feedback,
	output logic cs_at_max,
	output logic cs_at_soft_start,
	output logic cs_at_short
);
	logic [9:0] ramp = 10'h000; // primary current, back to zero once off
	// current builds only while the switch conducts
	always_ff @(posedge clk) begin
		ramp <= gate_drive_out ? ramp + 10'h001 : 10'h000;
	end
	// comparators fall with the current, so no stale level survives the pulse
	assign cs_at_feedback = !sense_open && ramp >= fb_lvl;
	assign cs_at_max = !sense_open && ramp >= MAX_LVL;
	assign cs_at_soft_start = !sense_open && ramp >= {3'b000, ss_setpoint_code, 2'b00} + 10'h004;
	assign cs_at_short = short_en && gate_drive_out; // shorted winding: instant overshoot
endmodule

// ### dv/test_light_load_burst_softstart.sv
// self-checking bench for the light-load burst and soft-start core
// assumes the core, switch model and checker compiled before it
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_light_load_burst_softstart;
	import llbs_pkg::*;
	localparam int unsigned HOLD = 4000; // longer than one three-pulse burst
	logic clk = 0, arst_n = 0, fb_below_fold_start = 0, fb_below_fold_end = 0, fb_below_freeze = 0;
	logic fb_skip_in = 0, fb_above_skip_out = 0, fb_above_transient = 0, fb_above_overpower = 0;
	logic line_cmp = 0, line_sample = 0, reg_wr = 0, reg_rd = 0, short_en = 0, sense_open = 0;
	logic [4:0] fold_code = 0, line_code = 0;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic [9:0] fb_lvl = 10'd60;
	logic cs_at_feedback, cs_at_max, cs_at_soft_start, cs_at_short, gate_drive_out, protect_mode;
	logic low_power, setpoint_freeze, overpower_enable, line_peak_valid, line_peak_reset, g_q = 0;
	logic [4:0] ss_setpoint_code, line_peak;
	logic [1:0] seq [9] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b10, 2'b00, 2'b01, 2'b00, 2'b01}; // {cmp, sample}
	int bad_count = 0, checks_done = 0, cyc = 0, rises = 0, hi = 0, width = 0, per = 0, t_rise = 0, n, t0;
	llbs_core #(.SS_CYCLES(320), .HOLD_CYCLES(HOLD), .BURST_MIN(3)) llbs_core_inst (.*);
	llbs_switch_model llbs_switch_model_inst (.*);
	always #12.5 clk = ~clk;
	// pulse monitor: count starts, last width and last period
	always @(posedge clk) begin
		cyc <= cyc + 1;
		g_q <= gate_drive_out;
		hi <= gate_drive_out ? hi + 1 : 0;
		if (gate_drive_out && !g_q) begin
			rises <= rises + 1;
			t_rise <= cyc;
			per <= cyc - t_rise;
		end
		if (!gate_drive_out && g_q) begin
			width <= hi;
		end
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read strobe, then masked compare in the one cycle the data stand
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		`CHK(reg_rdata & m, e)
		@(posedge clk);
	endtask
	task automatic cyc_wait(input int k);
		repeat (k) @(posedge clk);
	endtask
	// bounded wait for the next pulse start
	task automatic next_rise(input int lim);
		int k;
		int r;
		k = 0;
		r = rises;
		while (rises == r && k < lim) begin
			@(posedge clk);
			k++;
		end
	endtask
	task automatic summarize;
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// watchdog sized well above the full sequence
	initial begin
		cyc_wait(80000);
		bad_count++;
		summarize();
	end
	initial begin
		cyc_wait(5);
		arst_n <= 1'b1;
		cyc_wait(6);
		// control register, write-only place and unmapped read
		rd(REG_CTRL, 8'hFF, CTRL_RESET);
		wr(REG_CTRL, 8'hFE);
		rd(REG_CTRL, 8'hFF, 8'h00);
		wr(4'h3, 8'h00);
		wr(REG_CTRL, 8'hFF);
		rd(REG_CTRL, 8'hFF, 8'h01);
		rd(4'hF, 8'hFF, 8'h00);
		cyc_wait(400);
		`CHK(ss_setpoint_code, 5'h1F)
		rd(REG_STATUS, 8'h20, 8'h20);
		cyc_wait(2000);
		`CHK(per >= NOM_P - JIT_P - 1 && per <= NOM_P + JIT_P + 1, 1'b1)
		// stop level at once: only blanking holds the pulse
		fb_lvl <= 10'd1;
		cyc_wait(1400);
		`CHK(width >= LEB_CYC && width <= LEB_CYC + 3, 1'b1)
		fb_lvl <= 10'h3FF;
		cyc_wait(1400);
		`CHK(width >= 150 && width <= 156, 1'b1)
		sense_open <= 1'b1;
		cyc_wait(1400);
		`CHK(width >= (NOM_P - JIT_P) * DUTY_NUM / 64 && width <= MAX_ON_CYC + 1, 1'b1)
		sense_open <= 1'b0;
		fb_lvl <= 10'd100;
		fb_below_fold_start <= 1'b1;
		fold_code <= 5'h1F;
		fb_below_fold_end <= 1'b1;
		cyc_wait(5000);
		`CHK(per >= MIN_P - JIT_P - 1 && per <= MIN_P + JIT_P + 1, 1'b1)
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			fb_above_overpower <= i[0];
			fb_below_freeze <= i[0];
			cyc_wait(8);
			`CHK(overpower_enable, i[0])
			`CHK(setpoint_freeze, i[0])
		end
		fb_below_fold_start <= 1'b0;
		fb_below_fold_end <= 1'b0;
		// skip entry raised in mid-pulse: that pulse runs to its peak
		@(posedge clk iff gate_drive_out);
		fb_skip_in <= 1'b1;
		cyc_wait(700);
		`CHK(width >= 100, 1'b1)
		`CHK(low_power, 1'b1)
		n = rises;
		cyc_wait(1500);
		`CHK(rises, n)
		// skip exit opens a burst; immediate re-entry still yields the minimum
		fb_skip_in <= 1'b0;
		fb_above_skip_out <= 1'b1;
		t0 = cyc;
		cyc_wait(8);
		rd(REG_STATUS, 8'h03, 8'h02);
		fb_skip_in <= 1'b1;
		fb_above_skip_out <= 1'b0;
		cyc_wait(2600);
		`CHK(rises - n, 3)
		fb_skip_in <= 1'b0;
		fb_above_skip_out <= 1'b1;
		n = rises;
		next_rise(HOLD);
		`CHK(t_rise - t0 >= HOLD && t_rise - t0 <= HOLD + 700, 1'b1)
		fb_skip_in <= 1'b1;
		fb_above_skip_out <= 1'b0;
		cyc_wait(HOLD + 1000);
		n = rises;
		cyc_wait(500);
		`CHK(rises, n)
		fb_skip_in <= 1'b0;
		fb_above_skip_out <= 1'b1;
		next_rise(700);
		`CHK(rises, n + 1)
		fb_skip_in <= 1'b1;
		fb_above_skip_out <= 1'b0;
		cyc_wait(2600);
		n = rises;
		fb_skip_in <= 1'b0;
		fb_above_transient <= 1'b1;
		next_rise(700);
		`CHK(rises, n + 1)
		rd(REG_STATUS, 8'h03, 8'h00);
		// line peak: a comparator edge after one sample clock restarts the count
		line_code <= 5'h15;
		foreach (seq[i]) begin
			{line_cmp, line_sample} <= seq[i];
			cyc_wait(5);
			if (i == 7) begin
				`CHK(line_peak_valid, 1'b0)
			end
		end
		`CHK(line_peak_valid, 1'b1)
		`CHK(line_peak, 5'h15)
		rd(REG_LINE, 8'hFF, 8'h15);
		short_en <= 1'b1;
		next_rise(700);
		cyc_wait(10);
		`CHK(protect_mode, 1'b1)
		n = rises;
		cyc_wait(1500);
		`CHK(rises, n)
		arst_n <= 1'b0;
		short_en <= 1'b0;
		cyc_wait(5);
		arst_n <= 1'b1;
		cyc_wait(6);
		`CHK(protect_mode, 1'b0)
		summarize();
	end
endmodule
